// >>> crc_fifo_shift_engine.sv
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/10ps
// Functional notes
// - shifting only happens while shift_go is one.
// - fifo depth 8 when length field above 7, else 16.
// - count increments by one when a word is written.
// - shifter runs while go set and count nonzero.
// - count decrements when a word's last bit is shifted.
// - each word takes length+1 shift clocks.
// - full flag set when count equals depth.
// - empty flag set when count is zero.
// - write while full wraps count to zero, no interrupt.
// - interrupt pulse when count goes one to zero by shifting.
// - sleep freezes draining and shifting, while bus writes other than the result clear still land; resumes afterwards.
// - idle stops module only if idle_stop_control set; events still pass.
module crc_fifo_shift_engine
  import crc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic sleep_req,
  input wire logic idle_req,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic crc_irq
);
  logic shift_go;
  logic idle_stop_control;
  logic [3:0] poly_length_field;
  logic [CRC_W-1:0] poly;
  logic [4:0] valid_word_count;
  logic fifo_full_flag;
  logic fifo_empty_flag;
  logic [DATA_W-1:0] next_prdata;
  logic next_pslverr;
  logic next_irq;
  logic next_go;
  logic next_idle_stop;
  logic [3:0] next_len;
  logic [CRC_W-1:0] next_poly;
  logic [4:0] next_count;
  logic run;
  logic wr;
  logic rd;
  logic data_wr;
  logic clear_crc;
  logic skid_in_ready;
  logic skid_out_valid;
  logic eng_ready;
  logic word_done;
  logic wrap;
  word_t in_word;
  word_t skid_word;
  logic [CRC_W-1:0] crc;
  logic setup;
  logic push;
  logic pop;
  logic [16:0] len_mask;
  logic [3:0] wptr;
  logic [3:0] next_wptr;
  logic [3:0] rptr;
  logic [3:0] next_rptr;
  logic [4:0] stored;
  logic [4:0] next_stored;
  word_t store [FIFO_MAX];
  word_t next_store [FIFO_MAX];
  word_t head_word;
  logic head_valid;

  // one map decode used only by the error check; the register paths decode in their own case
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == ADDR_CTRL) || (a == ADDR_STAT) || (a == ADDR_POLY) ||
      (a == ADDR_DATA) || (a == ADDR_RESULT);
  endfunction

  // frozen in sleep or in idle with stop set; bus side still answers
  assign run = ce && !sleep_req && !(idle_req && idle_stop_control);
  assign wr = psel && penable && pwrite;
  // reads and errors decode in setup so the answer stands at the access edge
  assign setup = psel && !penable;
  assign rd = setup && !pwrite;
  assign data_wr = wr && (paddr == ADDR_DATA);
  assign wrap = data_wr && fifo_full_flag;
  assign push = data_wr && !fifo_full_flag && (stored != DEPTH_SHORT);
  assign len_mask = (17'h00002 << poly_length_field) - 17'h00001;
  assign in_word.data = pwdata[CRC_W-1:0] & len_mask[CRC_W-1:0];
  // words wait here until go, so a roll-over can still flush them
  assign head_valid = (stored != COUNT_RESET) && shift_go;
  assign head_word = store[rptr];
  assign pop = run && head_valid && skid_in_ready;
  assign in_word.len = poly_length_field;
  assign clear_crc = wr && (paddr == ADDR_RESULT);
  assign fifo_full_flag = (valid_word_count >= fifo_depth(poly_length_field));
  assign fifo_empty_flag = (valid_word_count == COUNT_RESET);

  crc_skid u_skid (
    .pclk(pclk),
    .presetn(presetn),
    .ce(run),
    .in_valid(head_valid),
    .in_ready(skid_in_ready),
    .in_word(head_word),
    .out_valid(skid_out_valid),
    .out_ready(eng_ready),
    .out_word(skid_word)
  );

  crc_shifter u_shift (
    .pclk(pclk),
    .presetn(presetn),
    .ce(run),
    .go(shift_go),
    .poly(poly),
    .clear(clear_crc),
    .in_valid(skid_out_valid),
    .in_ready(eng_ready),
    .in_word(skid_word),
    .word_done(word_done),
    .crc(crc)
  );

  // storage proper; skid and engine hold at most three more words and the
  // count covers them all, so the store cannot overflow
  always_comb begin
    next_store = store;
    next_wptr = wptr;
    next_rptr = rptr;
    next_stored = stored;
    if (wrap) begin
      // roll-over drops what waits here; a word already in the engine
      // still finishes, a known limitation
      next_wptr = 4'h0;
      next_rptr = 4'h0;
      next_stored = COUNT_RESET;
    end else begin
      if (push) begin
        next_store[wptr] = in_word;
        next_wptr = wptr + 4'h1;
      end
      if (pop) begin
        next_rptr = rptr + 4'h1;
      end
      next_stored = stored + {4'h0, push} - {4'h0, pop};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr <= 4'h0;
      rptr <= 4'h0;
      stored <= COUNT_RESET;
      for (int i = 0; i < FIFO_MAX; i++) begin
        store[i] <= '0;
      end
    end else if (ce && (run || data_wr)) begin
      wptr <= next_wptr;
      rptr <= next_rptr;
      stored <= next_stored;
      store <= next_store;
    end
  end

  // count tracks words not yet fully shifted, wherever they sit
  always_comb begin
    next_count = valid_word_count;
    next_irq = 1'b0;
    if (wrap) begin
      next_count = COUNT_RESET;
    end else begin
      if (push) begin
        next_count = next_count + 5'h01;
      end
      if (word_done && run && (valid_word_count != COUNT_RESET)) begin
        next_count = next_count - 5'h01;
        next_irq = (valid_word_count == 5'h01) && !push;
      end
    end
  end

  always_comb begin
    next_go = shift_go;
    next_idle_stop = idle_stop_control;
    next_len = poly_length_field;
    next_poly = poly;
    next_prdata = '0;
    next_pslverr = 1'b0;
    if (wr) begin
      case (paddr)
        ADDR_CTRL: begin
          next_go = pwdata[CTRL_GO];
          next_idle_stop = pwdata[CTRL_IDLE_STOP];
          next_len = pwdata[CTRL_LEN_LSB +: 4];
        end
        ADDR_POLY: next_poly = pwdata[CRC_W-1:0];
        ADDR_DATA, ADDR_RESULT: begin
        end
        default: begin
        end
      endcase
    end
    if (setup && !mapped(paddr)) begin
      next_pslverr = 1'b1;
    end
    if (rd) begin
      case (paddr)
        ADDR_CTRL: begin
          next_prdata[CTRL_GO] = shift_go;
          next_prdata[CTRL_IDLE_STOP] = idle_stop_control;
          next_prdata[CTRL_LEN_LSB +: 4] = poly_length_field;
        end
        ADDR_STAT: next_prdata[6:0] = {fifo_empty_flag, fifo_full_flag, valid_word_count};
        ADDR_POLY: next_prdata[CRC_W-1:0] = poly;
        ADDR_DATA, ADDR_RESULT: next_prdata[CRC_W-1:0] = crc;
        default: next_prdata = '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_go <= 1'b0;
      idle_stop_control <= 1'b0;
      poly_length_field <= LEN_RESET;
      poly <= POLY_RESET;
      valid_word_count <= COUNT_RESET;
      crc_irq <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end else if (ce) begin
      shift_go <= next_go;
      idle_stop_control <= next_idle_stop;
      poly_length_field <= next_len;
      poly <= next_poly;
      if (run || wr) begin
        valid_word_count <= next_count;
      end
      crc_irq <= next_irq;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
      pready <= psel && !penable;
    end
  end

  a_count_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    ce && wrap |=> valid_word_count == 5'h00) else $error("count did not wrap");
  a_full_flag: assert property (@(posedge pclk) disable iff (!presetn)
    valid_word_count == fifo_depth(poly_length_field) |-> fifo_full_flag)
    else $error("full flag missing");
  a_empty_flag: assert property (@(posedge pclk) disable iff (!presetn)
    fifo_empty_flag == (valid_word_count == 5'h00)) else $error("empty flag wrong");
  a_no_go_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !shift_go && ce |=> !word_done) else $error("shift without go");
  a_irq_cause: assert property (@(posedge pclk) disable iff (!presetn)
    crc_irq |-> $past(valid_word_count) == 5'h01 && valid_word_count == 5'h00)
    else $error("irq without one to zero");
  a_sleep_freeze: assert property (@(posedge pclk) disable iff (!presetn)
    ce && sleep_req && !wr |=> $stable(valid_word_count)) else $error("moved in sleep");
  a_count_inc: assert property (@(posedge pclk) disable iff (!presetn)
    ce && push && !(word_done && run)
    |=> valid_word_count == $past(valid_word_count) + 5'h01) else $error("no increment");
  a_wptr_step: assert property (@(posedge pclk) disable iff (!presetn)
    ce && push |=> wptr == $past(wptr) + 4'h1)
    else $error("word not stored");
  a_store_bound: assert property (@(posedge pclk) disable iff (!presetn)
    stored <= DEPTH_SHORT) else $error("store overflow");
  a_depth_short: assert property (@(posedge pclk) disable iff (!presetn)
    poly_length_field <= 4'h7 && valid_word_count < 5'h10 |-> !fifo_full_flag)
    else $error("depth sixteen full early");
  a_frozen_crc: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !run |=> $stable(crc)) else $error("crc moved while frozen");
  a_wrap_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    ce && wrap |=> !crc_irq) else $error("irq after roll-over");

  // last word leaves the engine with nothing new arriving
  sequence s_last_word;
    ce && run && word_done && valid_word_count == 5'h01 && !push;
  endsequence
  a_irq_on_drain: assert property (@(posedge pclk) disable iff (!presetn)
    s_last_word |=> crc_irq) else $error("no irq at drain");
  a_depth_long: assert property (@(posedge pclk) disable iff (!presetn)
    poly_length_field > 4'h7 && valid_word_count == 5'h08 |-> fifo_full_flag)
    else $error("depth eight not full");
endmodule // crc_fifo_shift_engine

// >>> crc_pkg.sv
package crc_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CRC_W = 16;
  localparam int unsigned FIFO_MAX = 16;
  localparam logic [4:0] DEPTH_LONG = 5'h08;
  localparam logic [4:0] DEPTH_SHORT = 5'h10;
  localparam logic [3:0] LEN_LONG_MIN = 4'h7;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STAT = 12'h004;
  localparam logic [11:0] ADDR_POLY = 12'h008;
  localparam logic [11:0] ADDR_DATA = 12'h00c;
  localparam logic [11:0] ADDR_RESULT = 12'h010;
  localparam int unsigned CTRL_GO = 0;
  localparam int unsigned CTRL_IDLE_STOP = 1;
  localparam int unsigned CTRL_LEN_LSB = 8;
  localparam logic [3:0] LEN_RESET = 4'h0;
  localparam logic [CRC_W-1:0] POLY_RESET = 16'h0000;
  localparam logic [CRC_W-1:0] CRC_RESET = 16'h0000;
  localparam logic [4:0] COUNT_RESET = 5'h00;

  typedef struct packed {
    logic [CRC_W-1:0] data;
    logic [3:0] len;
  } word_t;

  function automatic logic [4:0] fifo_depth(input logic [3:0] len);
    fifo_depth = (len > LEN_LONG_MIN) ? DEPTH_LONG : DEPTH_SHORT;
  endfunction
endpackage

// >>> crc_skid.sv
`timescale 1ns/10ps
module crc_skid
  import crc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire word_t in_word,
  output logic out_valid,
  input wire logic out_ready,
  output word_t out_word
);
  logic [1:0] fill;
  logic [1:0] next_fill;
  word_t slot [2];
  word_t next_slot [2];
  logic push;
  logic pop;

  // two entries so a stalled engine never drops a word
  always_comb begin
    push = in_valid && (fill != 2'h2);
    pop = out_ready && (fill != 2'h0);
    next_slot = slot;
    next_fill = fill;
    if (pop) begin
      next_slot[0] = slot[1];
    end
    if (push) begin
      next_slot[(pop ? fill - 2'h1 : fill) == 2'h0 ? 0 : 1] = in_word;
    end
    next_fill = fill + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fill <= 2'h0;
      slot[0] <= '0;
      slot[1] <= '0;
    end else if (ce) begin
      fill <= next_fill;
      slot <= next_slot;
    end
  end

  assign in_ready = (fill != 2'h2);
  assign out_valid = (fill != 2'h0);
  assign out_word = slot[0];
endmodule // crc_skid

// >>> crc_shifter.sv
`timescale 1ns/10ps
module crc_shifter
  import crc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic go,
  input wire logic [CRC_W-1:0] poly,
  input wire logic clear,
  input wire logic in_valid,
  output logic in_ready,
  input wire word_t in_word,
  output logic word_done,
  output logic [CRC_W-1:0] crc
);
  logic busy;
  logic next_busy;
  logic [3:0] bitn;
  logic [3:0] next_bitn;
  word_t cur;
  word_t next_cur;
  logic [CRC_W-1:0] next_crc;
  logic fb;

  always_comb begin
    next_busy = busy;
    next_bitn = bitn;
    next_cur = cur;
    next_crc = crc;
    word_done = 1'b0;
    fb = crc[CRC_W-1] ^ cur.data[bitn];
    in_ready = !busy && go;
    if (clear) begin
      next_crc = CRC_RESET;
    end
    if (!busy && go && in_valid) begin
      next_cur = in_word;
      next_bitn = in_word.len;
      next_busy = 1'b1;
    end else if (busy && go) begin
      // msb first, one bit per clock
      next_crc = {crc[CRC_W-2:0], 1'b0} ^ (fb ? poly : '0);
      if (bitn == 4'h0) begin
        word_done = 1'b1;
        next_busy = 1'b0;
      end else begin
        next_bitn = bitn - 4'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
      bitn <= 4'h0;
      cur <= '0;
      crc <= CRC_RESET;
    end else if (ce) begin
      busy <= next_busy;
      bitn <= next_bitn;
      cur <= next_cur;
      crc <= next_crc;
    end
  end
endmodule // crc_shifter

// >>> crc_core_model.sv
`timescale 1ns/10ps
module crc_core_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end

  // one apb transfer; request held until pready is seen at a rising edge
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err, output logic late);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    late = (n >= 50);
    psel <= 1'b0;
    penable <= 1'b0;
    // released data lines carry no stale word
    pwdata <= ~d;
    paddr <= ~a;
  endtask
endmodule // crc_core_model

// >>> crc_fifo_shift_engine_tb.sv
`timescale 1ns/10ps
module crc_fifo_shift_engine_tb;
  import crc_pkg::*;
  logic pclk, presetn, ce, sleep_req, idle_req, psel, penable, pwrite;
  logic pready, pslverr, crc_irq, err, late;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, d32;
  logic [3:0] len;
  logic [15:0] exp_crc;
  int fails, checked, irqs, seed, n;

  crc_fifo_shift_engine DUT (.pclk(pclk), .presetn(presetn), .ce(ce),
    .sleep_req(sleep_req), .idle_req(idle_req), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .crc_irq(crc_irq));
  crc_core_model core (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  always @(posedge pclk) if (crc_irq === 1'b1) irqs <= irqs + 1;

  // msb first, init zero, x^16 implied above the taps
  function automatic logic [15:0] crc_step(logic [15:0] c, logic [15:0] d, logic [3:0] l);
    logic fb;
    for (int i = 15; i >= 0; i--) begin
      if (i <= l) begin
        fb = c[15] ^ d[i];
        c = {c[14:0], 1'b0};
        if (fb) c = c ^ 16'h1021;
      end
    end
    return c;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    core.xfer(wr, a, d, rd, err, late);
    if (late) begin
      fails++;
      finish_test;
    end
  endtask

  task automatic finish_test;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    finish_test;
  end

  initial begin
    seed = 94128;
    ce = 1'b1;
    sleep_req = 1'b0;
    idle_req = 1'b0;
    presetn = 1'b0;
    fails = 0;
    checked = 0;
    irqs = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    bus(1'b0, ADDR_STAT, 32'h0);
    check(rd & 32'h7f, 32'h40, "status after reset");
    bus(1'b0, 12'h014, 32'h0);
    check({31'h0, err}, 32'h1, "unmapped error");
    bus(1'b1, ADDR_POLY, 32'h1021);
    bus(1'b1, ADDR_RESULT, 32'h0);
    exp_crc = CRC_RESET;
    for (int i = 0; i < 6; i++) begin
      len = $random(seed);
      d32 = $random(seed);
      // corners: longest and shortest word
      if (i == 0) len = 4'hf;
      if (i == 1) len = 4'h0;
      exp_crc = crc_step(exp_crc, d32[15:0], len);
      bus(1'b1, ADDR_CTRL, {20'h0, len, 8'h00});
      bus(1'b1, ADDR_DATA, d32);
      @(posedge pclk);
      bus(1'b0, ADDR_STAT, 32'h0);
      check(rd & 32'h7f, 32'h01, "count held without go");
      sleep_req <= (i == 2);
      idle_req <= (i == 3 || i == 4);
      n = irqs;
      bus(1'b1, ADDR_CTRL, {20'h0, len, 6'h0, (i == 4), 1'b1});
      if (i == 2 || i == 4) begin
        repeat (30) @(posedge pclk);
        check(irqs, n, "frozen engine quiet");
        sleep_req <= 1'b0;
        idle_req <= 1'b0;
      end
      for (int k = 0; k < 60 && irqs == n; k++) @(posedge pclk);
      check(irqs, n + 1, "one pulse at drain");
      idle_req <= 1'b0;
      bus(1'b0, ADDR_STAT, 32'h0);
      check(rd & 32'h7f, 32'h40, "empty after drain");
      bus(1'b0, ADDR_RESULT, 32'h0);
      check({16'h0, rd[15:0]}, {16'h0, exp_crc}, "crc result");
    end
    // fill to depth with go low; depth 8 then rolls over, depth 16 drains
    for (int j = 0; j < 2; j++) begin
      len = (j == 0) ? 4'h8 : 4'h3;
      n = (len > LEN_LONG_MIN) ? 8 : 16;
      bus(1'b1, ADDR_CTRL, {20'h0, len, 8'h00});
      for (int i = 0; i < n; i++) begin
        d32 = $random(seed);
        if (j == 1) exp_crc = crc_step(exp_crc, d32[15:0], len);
        bus(1'b1, ADDR_DATA, d32);
      end
      bus(1'b0, ADDR_STAT, 32'h0);
      check(rd & 32'h7f, 32'h20 | n, "full at depth");
      n = irqs;
      if (j == 0) begin
        bus(1'b1, ADDR_DATA, 32'h0);
        bus(1'b0, ADDR_STAT, 32'h0);
        check(rd & 32'h7f, 32'h40, "roll-over to empty");
      end
      bus(1'b1, ADDR_CTRL, {20'h0, len, 8'h01});
      for (int k = 0; k < 300 && irqs == n; k++) @(posedge pclk);
      check(irqs, n + (j == 1), "drain pulse count");
    end
    bus(1'b0, ADDR_RESULT, 32'h0);
    check({16'h0, rd[15:0]}, {16'h0, exp_crc}, "crc after full drain");
    finish_test;
  end
endmodule // crc_fifo_shift_engine_tb
